// ---- ddr4_read_latency_burst_control.sv ----
// Read/write latency, burst length and read auto-precharge timing of the memory device
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module ddr4_read_latency_burst_control
  import ddr4_lat_pkg::*;
#(
  parameter int unsigned DEPTH = 80,   // Stages per pipe; the longest latency held is DEPTH plus one
  parameter int unsigned TW    = 7     // Tap index width
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              link_clk,
  input  wire logic              cs_n,
  input  wire logic              cmd_read,
  input  wire logic              cmd_write,
  input  wire logic              addr_a12,
  input  wire logic              addr_a10,
  input  wire logic [3:0]        cmd_bank,
  input  wire logic              dll_locked,
  output logic                   rd_drive,
  output logic                   rd_chop,
  output logic                   wr_sample,
  output logic                   wr_chop,
  output logic                   precharge_start,
  output logic      [3:0]        precharge_bank,
  output logic                   wr_timing_ok
);

  // ==========================================================================
  // Bus domain state
  // ==========================================================================
  typedef struct packed {
    cfg_t        regs;     // Software view of the configuration
    cfg_t        xfer;     // Snapshot held stable while crossing
    logic        req;      // Toggle launched with each snapshot
    logic        pend;     // Software wrote since the last launch
    logic        ack_s1;   // Acknowledge synchroniser, first stage
    logic        ack_s2;   // Acknowledge synchroniser, second stage
    logic        lock_s1;  // Lock synchroniser, first stage
    logic        lock_s2;  // Lock synchroniser, second stage
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bus_state_t;

  bus_state_t bus_ff;      // Registered bus state
  bus_state_t nxt_bus;     // Next bus state

  logic [7:0] bus_rl;      // Total read latency from software view
  logic [7:0] bus_wl;      // Total write latency from software view
  logic       bus_busy;    // Snapshot not yet acknowledged
  logic       lnk_ack;     // Acknowledge toggle as driven by the link side

  // Totals shown to software follow the same sum the link uses
  always_comb begin
    bus_rl = 8'(bus_ff.regs.cas_read_latency) +
             8'(bus_ff.regs.additive_latency) +
             (bus_ff.regs.parity_en ? PARITY_LAT : 8'h00);
    bus_wl = 8'(bus_ff.regs.cas_write_latency) +
             8'(bus_ff.regs.additive_latency) +
             (bus_ff.regs.parity_en ? PARITY_LAT : 8'h00);
    bus_busy = bus_ff.req ^ bus_ff.ack_s2;
  end

  // APB slave, one wait state, plus the launch of configuration snapshots
  always_comb begin
    nxt_bus = bus_ff;
    if (clk_en) begin
      nxt_bus.ack_s1  = lnk_ack;
      nxt_bus.ack_s2  = bus_ff.ack_s1;
      nxt_bus.lock_s1 = dll_locked;
      nxt_bus.lock_s2 = bus_ff.lock_s1;
      // Launch only when idle so the snapshot never moves while sampled
      if (!bus_busy && bus_ff.pend) begin
        nxt_bus.xfer = bus_ff.regs;
        nxt_bus.req  = ~bus_ff.req;
        nxt_bus.pend = 1'b0;
      end
      if (psel && penable && !bus_ff.pready) begin
        // First access cycle: decode and prepare the answer
        nxt_bus.pready  = 1'b1;
        nxt_bus.pslverr = 1'b0;
        nxt_bus.prdata  = 32'h0000_0000;
        case (paddr)
          OFF_MODE0: begin
            nxt_bus.prdata[BC_LSB +: 2]  = bus_ff.regs.burst_ctrl;
            nxt_bus.prdata[RTP_LSB +: 3] = bus_ff.regs.rtp_code;
          end
          OFF_LAT: begin
            nxt_bus.prdata[CL_LSB +: 6]  = bus_ff.regs.cas_read_latency;
            nxt_bus.prdata[AL_LSB +: 6]  = bus_ff.regs.additive_latency;
            nxt_bus.prdata[CWL_LSB +: 6] = bus_ff.regs.cas_write_latency;
          end
          OFF_CTRL: begin
            nxt_bus.prdata[PAR_BIT]      = bus_ff.regs.parity_en;
            nxt_bus.prdata[CAL_LSB +: 4] = bus_ff.regs.cal_clks;
            nxt_bus.prdata[CALEN_BIT]    = bus_ff.regs.cal_en;
          end
          OFF_STATUS: begin
            nxt_bus.prdata[ST_LOCK_BIT]  = bus_ff.lock_s2;
            nxt_bus.prdata[ST_BUSY_BIT]  = bus_busy | bus_ff.pend;
          end
          OFF_TOTAL: begin
            nxt_bus.prdata[7:0]             = bus_rl;
            nxt_bus.prdata[TOT_WL_LSB +: 8] = bus_wl;
          end
          default: begin
            // Unmapped: error answer, data reads zero
            nxt_bus.pslverr = 1'b1;
          end
        endcase
      end else if (psel && penable && bus_ff.pready) begin
        // Completing edge: writes take effect here and nowhere else
        nxt_bus.pready  = 1'b0;
        nxt_bus.pslverr = 1'b0;
        nxt_bus.prdata  = 32'h0000_0000;
        if (pwrite) begin
          case (paddr)
            OFF_MODE0: begin
              nxt_bus.regs.burst_ctrl = pwdata[BC_LSB +: 2];
              nxt_bus.regs.rtp_code   = pwdata[RTP_LSB +: 3];
              nxt_bus.pend            = 1'b1;
            end
            OFF_LAT: begin
              nxt_bus.regs.cas_read_latency  = pwdata[CL_LSB +: 6];
              nxt_bus.regs.additive_latency  = pwdata[AL_LSB +: 6];
              nxt_bus.regs.cas_write_latency = pwdata[CWL_LSB +: 6];
              nxt_bus.pend                   = 1'b1;
            end
            OFF_CTRL: begin
              nxt_bus.regs.parity_en = pwdata[PAR_BIT];
              nxt_bus.regs.cal_clks  = pwdata[CAL_LSB +: 4];
              nxt_bus.regs.cal_en    = pwdata[CALEN_BIT];
              nxt_bus.pend           = 1'b1;
            end
            default: begin
              // Read-only or unmapped: no effect
            end
          endcase
        end
      end else begin
        nxt_bus.pready  = 1'b0;
        nxt_bus.pslverr = 1'b0;
        nxt_bus.prdata  = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ff      <= '0;
      bus_ff.regs <= CFG_RST;
      bus_ff.xfer <= CFG_RST;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  assign prdata  = bus_ff.prdata;
  assign pready  = bus_ff.pready;
  assign pslverr = bus_ff.pslverr;

  // ==========================================================================
  // Link domain reset: asserted at once, released on the link clock
  // ==========================================================================
  logic [1:0] lrst_ff;     // Release synchroniser
  logic       lrst_n;      // Link domain reset, active low

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_ff <= 2'b00;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end

  assign lrst_n = lrst_ff[1];

  // ==========================================================================
  // Link domain state
  // ==========================================================================
  typedef struct packed {
    logic       ce_s1;     // Clock enable synchroniser stages
    logic       ce_s2;
    logic       req_s1;    // Request toggle synchroniser stages
    logic       req_s2;
    logic       req_s3;    // Edge detection stage
    logic       ack;       // Acknowledge toggle back to the bus side
    cfg_t       cfg;       // Configuration in force at the link
    logic       lock_s1;   // Loop lock synchroniser stages
    logic       lock_s2;
    logic [7:0] cs_hist;   // Bit k: chip select seen k+1 clocks ago
    logic [2:0] rd_cnt;    // Read clocks still to drive
    logic [2:0] wr_cnt;    // Write clocks still to sample
    logic       rd_drive;
    logic       rd_chop;
    logic       wr_sample;
    logic       wr_chop;
    logic       pre_start;
    logic [3:0] pre_bank;
    logic       wr_ok;
  } lnk_state_t;

  lnk_state_t lnk_ff;      // Registered link state
  lnk_state_t nxt_lnk;     // Next link state

  assign lnk_ack = lnk_ff.ack;

  logic          lnk_en;   // Synchronised clock enable
  logic          cmd_cs;   // Command is qualified this clock
  logic          rd_cmd;   // Read taken this clock
  logic          wr_cmd;   // Write taken this clock
  logic          chop;     // Command runs as four-beat chop
  logic [2:0]    cal_idx;  // History index for chip-select latency
  logic [7:0]    par_add;  // Parity latency added to both totals
  logic [7:0]    rl;       // Total read latency
  logic [7:0]    wl;       // Total write latency
  logic [7:0]    rtp;      // Read-to-precharge delay in clocks
  logic [7:0]    ap_lat;   // Read to internal precharge
  logic [TW-1:0] rd_tap;
  logic [TW-1:0] wr_tap;
  logic [TW-1:0] ap_tap;
  logic [1:0]    rd_out;   // {valid, chop} at read latency
  logic [1:0]    wr_out;   // {valid, chop} at write latency
  logic [4:0]    ap_out;   // {valid, bank} at precharge time

  // Tap below the pipe's own stages saturates to the shortest delay
  function automatic logic [TW-1:0] to_tap(input logic [7:0] lat);
    to_tap = (lat > LAT_OFFSET) ? TW'(lat - LAT_OFFSET) : '0;
  endfunction : to_tap

  // Command qualification, burst choice and latency sums
  always_comb begin
    lnk_en  = lnk_ff.ce_s2;
    cal_idx = (lnk_ff.cfg.cal_clks == 4'h0) ? 3'h0
                                            : 3'(lnk_ff.cfg.cal_clks - 4'h1);
    cmd_cs  = lnk_ff.cfg.cal_en ? lnk_ff.cs_hist[cal_idx] : ~cs_n;
    rd_cmd  = cmd_cs & cmd_read;
    wr_cmd  = cmd_cs & cmd_write;
    case (lnk_ff.cfg.burst_ctrl)
      BURST_FIXED4: chop = 1'b1;
      BURST_OTF:    chop = ~addr_a12;
      BURST_FIXED8: chop = 1'b0;
      default:      chop = 1'b0;                 // Reserved code runs eight
    endcase
    par_add = lnk_ff.cfg.parity_en ? PARITY_LAT : 8'h00;
    rl      = 8'(lnk_ff.cfg.cas_read_latency) +
              8'(lnk_ff.cfg.additive_latency) + par_add;
    wl      = 8'(lnk_ff.cfg.cas_write_latency) +
              8'(lnk_ff.cfg.additive_latency) + par_add;
    rtp     = RTP_BASE + 8'(lnk_ff.cfg.rtp_code);
    ap_lat  = 8'(lnk_ff.cfg.additive_latency) + rtp;
    rd_tap  = to_tap(rl);
    wr_tap  = to_tap(wl);
    ap_tap  = to_tap(ap_lat);
  end

  // Delay lines; a new configuration retimes commands already in flight
  latency_tap #(.W(2), .DEPTH(DEPTH), .TW(TW)) u_rd_pipe (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .en    (lnk_en),
    .din   ({rd_cmd, chop}),
    .tap   (rd_tap),
    .dout  (rd_out)
  );

  latency_tap #(.W(2), .DEPTH(DEPTH), .TW(TW)) u_wr_pipe (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .en    (lnk_en),
    .din   ({wr_cmd, chop}),
    .tap   (wr_tap),
    .dout  (wr_out)
  );

  latency_tap #(.W(5), .DEPTH(DEPTH), .TW(TW)) u_ap_pipe (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .en    (lnk_en),
    .din   ({rd_cmd & addr_a10, cmd_bank}),
    .tap   (ap_tap),
    .dout  (ap_out)
  );

  // Burst windows, precharge pulse and configuration capture
  always_comb begin
    nxt_lnk        = lnk_ff;
    // Clock enable synchroniser stages run even while frozen so the enable can return
    nxt_lnk.ce_s1  = clk_en;
    nxt_lnk.ce_s2  = lnk_ff.ce_s1;
    if (lnk_en) begin
      nxt_lnk.req_s1  = bus_ff.req;
      nxt_lnk.req_s2  = lnk_ff.req_s1;
      nxt_lnk.req_s3  = lnk_ff.req_s2;
      nxt_lnk.lock_s1 = dll_locked;
      nxt_lnk.lock_s2 = lnk_ff.lock_s1;
      // Snapshot is stable until the acknowledge returns
      if (lnk_ff.req_s2 ^ lnk_ff.req_s3) begin
        nxt_lnk.cfg = bus_ff.xfer;
        nxt_lnk.ack = lnk_ff.req_s2;
      end
      nxt_lnk.cs_hist = {lnk_ff.cs_hist[6:0], ~cs_n};
      // Read data window opens exactly at the total read latency
      if (rd_out[1]) begin
        nxt_lnk.rd_cnt   = rd_out[0] ? CLKS_BEAT4 : CLKS_BEAT8;
        nxt_lnk.rd_chop  = rd_out[0];
        nxt_lnk.rd_drive = 1'b1;
      end else begin
        nxt_lnk.rd_cnt   = (lnk_ff.rd_cnt != 3'h0) ?
                           lnk_ff.rd_cnt - 3'h1 : 3'h0;
        nxt_lnk.rd_drive = (lnk_ff.rd_cnt > 3'h1);
      end
      // Write sampling only with the loop locked; otherwise data is ignored
      if (wr_out[1] && lnk_ff.lock_s2) begin
        nxt_lnk.wr_cnt    = wr_out[0] ? CLKS_BEAT4 : CLKS_BEAT8;
        nxt_lnk.wr_chop   = wr_out[0];
        nxt_lnk.wr_sample = 1'b1;
      end else begin
        nxt_lnk.wr_cnt    = (lnk_ff.wr_cnt != 3'h0 && lnk_ff.lock_s2) ?
                            lnk_ff.wr_cnt - 3'h1 : 3'h0;
        nxt_lnk.wr_sample = (lnk_ff.wr_cnt > 3'h1) && lnk_ff.lock_s2;
      end
      nxt_lnk.wr_ok     = lnk_ff.lock_s2;
      // Internal precharge begins after additive plus read-to-precharge
      nxt_lnk.pre_start = ap_out[4];
      if (ap_out[4]) begin
        nxt_lnk.pre_bank = ap_out[3:0];
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lnk_ff     <= '0;
      lnk_ff.cfg <= CFG_RST;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  assign rd_drive        = lnk_ff.rd_drive;
  assign rd_chop         = lnk_ff.rd_chop;
  assign wr_sample       = lnk_ff.wr_sample;
  assign wr_chop         = lnk_ff.wr_chop;
  assign precharge_start = lnk_ff.pre_start;
  assign precharge_bank  = lnk_ff.pre_bank;
  assign wr_timing_ok    = lnk_ff.wr_ok;

endmodule : ddr4_read_latency_burst_control

`default_nettype wire

// ---- ddr4_lat_pkg.sv ----
// Shared constants, field layouts and the configuration word of the latency block
package ddr4_lat_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the APB side)
  // ==========================================================================
  localparam int unsigned APB_AW      = 8;
  localparam logic [7:0]  OFF_MODE0   = 8'h00;  // Burst control, read-to-precharge code
  localparam logic [7:0]  OFF_LAT     = 8'h04;  // Read, additive and write latency
  localparam logic [7:0]  OFF_CTRL    = 8'h08;  // Parity and chip-select latency mode
  localparam logic [7:0]  OFF_STATUS  = 8'h0c;  // Read-only state
  localparam logic [7:0]  OFF_TOTAL   = 8'h10;  // Read-only total latencies

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned BC_LSB      = 0;      // Burst control, 2 bits
  localparam int unsigned RTP_LSB     = 9;      // Read-to-precharge code, 3 bits
  localparam int unsigned CL_LSB      = 0;      // CAS read latency, 6 bits
  localparam int unsigned AL_LSB      = 8;      // Additive latency, 6 bits
  localparam int unsigned CWL_LSB     = 16;     // CAS write latency, 6 bits
  localparam int unsigned PAR_BIT     = 0;      // Parity enable
  localparam int unsigned CAL_LSB     = 4;      // Chip-select latency, 4 bits
  localparam int unsigned CALEN_BIT   = 8;      // Chip-select latency enable
  localparam int unsigned ST_LOCK_BIT = 0;      // Loop locked
  localparam int unsigned ST_BUSY_BIT = 1;      // Configuration still crossing
  localparam int unsigned TOT_WL_LSB  = 8;      // Total write latency in total reg

  // ==========================================================================
  // Encodings and timing figures
  // ==========================================================================
  localparam logic [1:0] BURST_FIXED8 = 2'h0;   // Always eight beats
  localparam logic [1:0] BURST_OTF    = 2'h1;   // Chosen by address bit 12
  localparam logic [1:0] BURST_FIXED4 = 2'h2;   // Always four-beat chop
  localparam logic [7:0] PARITY_LAT   = 8'h04;  // Parity latency in clocks
  localparam logic [7:0] RTP_BASE     = 8'h05;  // Code 001 gives six clocks
  localparam logic [2:0] CLKS_BEAT8   = 3'h4;   // Eight beats, double rate
  localparam logic [2:0] CLKS_BEAT4   = 3'h2;   // Four beats, double rate
  localparam logic [7:0] LAT_OFFSET   = 8'h02;  // Stages spent outside the tap

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] BC_RST       = 2'h0;
  localparam logic [2:0] RTP_RST      = 3'h1;
  localparam logic [5:0] CL_RST       = 6'h0b;
  localparam logic [5:0] AL_RST       = 6'h00;
  localparam logic [5:0] CWL_RST      = 6'h09;
  localparam logic [3:0] CAL_RST      = 4'h3;

  // Configuration word carried from the bus domain to the link domain
  typedef struct packed {
    logic [1:0] burst_ctrl;
    logic [2:0] rtp_code;
    logic [5:0] cas_read_latency;
    logic [5:0] additive_latency;
    logic [5:0] cas_write_latency;
    logic       parity_en;
    logic       cal_en;
    logic [3:0] cal_clks;
  } cfg_t;

  localparam cfg_t CFG_RST = '{BC_RST, RTP_RST, CL_RST, AL_RST, CWL_RST,
                               1'b0, 1'b0, CAL_RST};

endpackage : ddr4_lat_pkg

// ---- latency_tap.sv ----
// Shift-register delay line with a run-time selectable tap
`timescale 1ns/100ps
`default_nettype none

module latency_tap
  import ddr4_lat_pkg::*;
#(
  parameter int unsigned W     = 2,
  parameter int unsigned DEPTH = 80,
  parameter int unsigned TW    = 7
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          en,
  input  wire logic [W-1:0]  din,
  input  wire logic [TW-1:0] tap,
  output logic      [W-1:0]  dout
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] sr;  // Stage k holds the entry of k+1 clocks ago
  } tap_state_t;

  tap_state_t st_ff;              // Registered state
  tap_state_t nxt_st;             // Next state

  // Shift once per enabled clock
  always_comb begin
    nxt_st = st_ff;
    if (en) begin
      nxt_st.sr = {st_ff.sr[DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Out-of-range taps read as idle rather than wrapping
  assign dout = (int'(tap) < DEPTH) ? st_ff.sr[tap] : '0;

endmodule : latency_tap

`default_nettype wire

// ---- ddr4_lat_properties.sv ----
// Port-level checks on the latency block
`timescale 1ns/100ps
`default_nettype none
module ddr4_lat_properties #(
  parameter int unsigned DEPTH = 80,
  parameter int unsigned TW    = 7
) (
  input wire logic        pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [31:0] prdata,
  input wire logic        link_clk, rd_drive, rd_chop, wr_sample, wr_chop,
  input wire logic        precharge_start, wr_timing_ok,
  input wire logic [3:0]  precharge_bank
);
  // ==========================================================
  // Bus side: one wait state, one-cycle answer
  sequence acc_start_s;
    psel && $rose(penable);
  endsequence
  wait_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_start_s |-> !pready ##1 pready) else $error("pready not on 2nd access");
  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready longer than one cycle");
  slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
  // ==========================================================
  // Link side: burst windows follow the chop flag, writes need lock, precharge is a one-clock pulse
  sequence two_beat_s;
    rd_drive [*2] ##1 !rd_drive;
  endsequence
  sequence four_beat_s;
    rd_drive [*4] ##1 !rd_drive;
  endsequence
  rd_window_a: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(rd_drive) |-> two_beat_s or four_beat_s) else $error("read window");
  rd_chop_len_a: assert property (@(posedge link_clk) disable iff (!presetn)
    $fell(rd_drive) |-> (rd_chop ? !$past(rd_drive, 3) : !$past(rd_drive, 5)
    && $past(rd_drive, 4))) else $error("read length disagrees with chop");
  wr_chop_len_a: assert property (@(posedge link_clk) disable iff (!presetn)
    $fell(wr_sample) |-> (wr_chop ? !$past(wr_sample, 3) : !$past(wr_sample, 5)
    && $past(wr_sample, 4))) else $error("write length disagrees with chop");
  chop_hold_a: assert property (@(posedge link_clk) disable iff (!presetn)
    rd_drive && $past(rd_drive) |-> $stable(rd_chop)) else $error("chop moved");
  wr_lock_a: assert property (@(posedge link_clk) disable iff (!presetn)
    wr_sample |-> wr_timing_ok) else $error("write window while unlocked");
  pre_pulse_a: assert property (@(posedge link_clk) disable iff (!presetn)
    precharge_start |=> !precharge_start) else $error("precharge pulse long");
  bank_hold_a: assert property (@(posedge link_clk) disable iff (!presetn)
    $changed(precharge_bank) |-> precharge_start) else $error("bank moved");
endmodule : ddr4_lat_properties
bind ddr4_read_latency_burst_control ddr4_lat_properties #(.DEPTH(DEPTH),
  .TW(TW)) props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .link_clk(link_clk), .rd_drive(rd_drive), .rd_chop(rd_chop),
  .wr_sample(wr_sample), .wr_chop(wr_chop), .wr_timing_ok(wr_timing_ok),
  .precharge_start(precharge_start), .precharge_bank(precharge_bank));
`default_nettype wire

// ---- ddr4_ctrl_model.sv ----
// Behavioural memory controller driving link commands
`timescale 1ns/100ps
`default_nettype none
module ddr4_ctrl_model (
  input  wire logic  link_clk,
  output logic       cs_n, cmd_read, cmd_write, addr_a12, addr_a10,
  output logic [3:0] cmd_bank
);
  // Idle: deselected, no command
  initial begin
    cs_n = 1'b1;
    {cmd_read, cmd_write, addr_a12, addr_a10, cmd_bank} = '0;
  end
  // One command; with chip-select latency the select leads by cal clocks
  task automatic issue(input logic rd, a12, a10, input logic [3:0] bank,
                       input int cal);
    @(posedge link_clk);
    cs_n <= 1'b0;
    if (cal > 0) begin
      @(posedge link_clk);
      cs_n <= 1'b1;
      repeat (cal - 1) @(posedge link_clk);
    end
    {cmd_read, cmd_write, addr_a12, addr_a10, cmd_bank} <=
      {rd, !rd, a12, a10, bank};
    @(posedge link_clk);
    // Command lines drop and address and bank lines flip, so a stale value can never pass as good
    cs_n <= 1'b1;
    {cmd_read, cmd_write, addr_a12, addr_a10, cmd_bank} <=
      {2'b00, !a12, !a10, ~bank};
  endtask : issue
  // No precharge, activate or termination traffic is ever sent
endmodule : ddr4_ctrl_model
`default_nettype wire

// ---- test_ddr4_read_latency_burst_control.sv ----
// Self-checking bench for the latency block
`timescale 1ns/100ps
`default_nettype none
module test_ddr4_read_latency_burst_control
  import ddr4_lat_pkg::*;
();
  logic pclk = 0, link_clk = 0, presetn = 0, psel = 0, penable = 0;
  logic pwrite = 0, dll_locked = 1, e, cs_n, cmd_read, cmd_write;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, rd_drive, rd_chop, wr_sample, wr_chop;
  logic precharge_start, wr_timing_ok, addr_a12, addr_a10;
  logic [3:0] precharge_bank, cmd_bank;
  int err_total = 0, checks_done = 0;
  always #5 pclk = ~pclk;
  always #80 link_clk = ~link_clk;
  ddr4_ctrl_model ctl (.link_clk(link_clk), .cs_n(cs_n), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .addr_a12(addr_a12), .addr_a10(addr_a10),
    .cmd_bank(cmd_bank));
  ddr4_read_latency_burst_control uut (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .cs_n(cs_n), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .addr_a12(addr_a12), .addr_a10(addr_a10),
    .cmd_bank(cmd_bank), .dll_locked(dll_locked), .rd_drive(rd_drive),
    .rd_chop(rd_chop), .wr_sample(wr_sample), .wr_chop(wr_chop),
    .precharge_start(precharge_start), .precharge_bank(precharge_bank),
    .wr_timing_ok(wr_timing_ok));
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin err_total++; close_out(); end
  endtask : apb
  // Write and wait until the link domain has taken the new setting
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb(1'b1, a, d);
    do begin apb(1'b0, OFF_STATUS, 32'h0); n++; end
    while (q[ST_BUSY_BIT] !== 1'b0 && n < 50);
    if (n >= 50) begin err_total++; close_out(); end
  endtask : cfg
  // Command, then count link clocks to the window and its width
  task automatic run(input int sel, input logic a12, a10, input logic [3:0] bank,
                     input int cal, lat, len, input logic chop);
    int n, w;
    logic s;
    n = 0;
    w = 0;
    ctl.issue(sel != 1, a12, a10, bank, cal);
    for (int i = 2; i <= 61; i++) begin
      @(posedge link_clk);
      #1 s = (sel == 0) ? rd_drive : (sel == 1) ? wr_sample : precharge_start;
      if (s === 1'b1) begin if (w == 0) n = i; w++; end
    end
    chk(32'(n), 32'(lat));
    chk(32'(w), 32'(len));
    if (sel == 2) chk(precharge_bank, bank);
    else if (len > 0) chk((sel == 0) ? rd_chop : wr_chop, chop);
  endtask : run
  task automatic t_regs;
    apb(0, OFF_MODE0, 0); chk(q, 32'h200);
    apb(0, OFF_LAT, 0); chk(q, 32'h0009000b);
    apb(0, OFF_CTRL, 0); chk(q, 32'h30);
    apb(1, OFF_TOTAL, 32'hffffffff); apb(0, OFF_TOTAL, 0); chk(q, 32'h090b);
    apb(0, 8'h20, 0); chk(e, 1);
  endtask : t_regs
  task automatic t_burst;
    run(0, 0, 0, 0, 0, 11, 4, 0);
    cfg(OFF_MODE0, 32'h201);
    run(0, 0, 0, 0, 0, 11, 2, 1);
    run(0, 1, 0, 0, 0, 11, 4, 0);
    run(1, 0, 0, 0, 0, 9, 2, 1);
    cfg(OFF_MODE0, 32'h202);
    run(0, 1, 0, 0, 0, 11, 2, 1);
    run(1, 1, 0, 0, 0, 9, 2, 1);
    cfg(OFF_MODE0, 32'h203);
    run(0, 0, 0, 0, 0, 11, 4, 0);
    cfg(OFF_MODE0, 32'h200);
  endtask : t_burst
  task automatic t_parity;
    cfg(OFF_CTRL, 32'h31);
    apb(0, OFF_TOTAL, 0); chk(q, 32'h0d0f);
    run(0, 1, 0, 0, 0, 15, 4, 0);
    run(1, 1, 0, 0, 0, 13, 4, 0);
    cfg(OFF_CTRL, 32'h131);
    run(0, 1, 0, 0, 3, 15, 4, 0);
    cfg(OFF_CTRL, 32'h30);
  endtask : t_parity
  task automatic t_precharge;
    cfg(OFF_LAT, 32'h0009090b);
    run(2, 1, 1, 4'h5, 0, 15, 1, 0);
    run(0, 1, 0, 0, 0, 20, 4, 0);
    cfg(OFF_LAT, 32'h0009000b);
  endtask : t_precharge
  task automatic t_lock(input logic lk, input int lat, len);
    int n;
    n = 0;
    @(posedge pclk) dll_locked <= lk;
    do begin @(posedge pclk); n++; end while (wr_timing_ok !== lk && n < 100);
    chk(wr_timing_ok, lk);
    apb(0, OFF_STATUS, 0); chk(q[ST_LOCK_BIT], lk);
    run(1, 1, 0, 0, 0, lat, len, 0);
  endtask : t_lock
  // Main sequence
  initial begin
    repeat (6) @(posedge link_clk);
    presetn <= 1'b1;
    repeat (6) @(posedge link_clk);
    t_regs();
    t_burst();
    t_parity();
    t_precharge();
    t_lock(1'b0, 0, 0);
    t_lock(1'b1, 9, 4);
    close_out();
  end
endmodule : test_ddr4_read_latency_burst_control
`default_nettype wire
